// file: pzps_pkg.sv
// Notes on behaviour
// [R1] default four phases; sensed-high phases two to four disabled
// [R2] only contiguous phase sets from phase one
// [R3] phase status register shows active outputs
// [R4] power-up samples select level and strap codes
// [R5] software may rewrite low-zone and threshold settings
// [R6] select changes ignored until output nominal
// [R7] select high keeps zone zero
// [R8] select mid sheds on periodic current samples
// [R9] threshold all-ones or saturated strap is disabled
// [R10] shedding held off until first nominal
// [R11] select low at enable: secondary strap zone
// [R12] low, secondary enabled: zone from 0x36[5:3]
// [R13] low re-entered: primary strap or 0x36[2:0]
// [R14] current versus thresholds picks zone per phases
// [R15] five strap codes map to zones per phases
// [R16] load-line strap gives address and percentage
// [R17] load-line percentage rewritable by software
// [R18] down jumps at once, up steps with delay
// [R19] upward move needs current below threshold-hysteresis
// [R20] strap results captured once, held until power-up
package pzps_pkg;

   // register offsets
   localparam logic [7:0] PZ_REG_PHASE_STAT = 8'h30;
   localparam logic [7:0] PZ_REG_TH1        = 8'h31;
   localparam logic [7:0] PZ_REG_TH2        = 8'h32;
   localparam logic [7:0] PZ_REG_TH3        = 8'h33;
   localparam logic [7:0] PZ_REG_HYST       = 8'h34;
   localparam logic [7:0] PZ_REG_DELAY      = 8'h35;
   localparam logic [7:0] PZ_REG_LOWZONE    = 8'h36;
   localparam logic [7:0] PZ_REG_LOADLINE   = 8'h37;
   localparam logic [7:0] PZ_REG_ZONE_STAT  = 8'h38;

   // field positions of the low zone override register
   localparam int PZ_LOW_PRI_LSB = 0;
   localparam int PZ_LOW_SEC_LSB = 3;
   localparam int PZ_LOW_SEC_EN  = 7;

   // reset and strap values
   localparam logic [7:0] PZ_HYST_RST   = 8'h10;
   localparam logic [7:0] PZ_DELAY_RST  = 8'h14;
   localparam logic [7:0] PZ_TH_OFF     = 8'hff;
   localparam logic [6:0] PZ_LL_FULL    = 7'h64;
   localparam logic [6:0] PZ_LL_NONE    = 7'h00;
   localparam logic [6:0] PZ_ADDR_BASE  = 7'h20;

   // zones and select levels
   localparam logic [2:0] PZ_ZONE0 = 3'h0;
   localparam logic [2:0] PZ_ZONE2 = 3'h2;
   localparam logic [2:0] PZ_ZONE3 = 3'h3;
   localparam logic [2:0] PZ_ZONE4 = 3'h4;
   localparam logic [1:0] PZ_PSI_LOW  = 2'h0;
   localparam logic [1:0] PZ_PSI_MID  = 2'h1;
   localparam logic [1:0] PZ_PSI_HIGH = 2'h2;

   // pin vector positions
   localparam int PZ_PIN_W    = 8;
   localparam int PZ_PIN_PSI  = 4;
   localparam int PZ_PIN_EN   = 6;
   localparam int PZ_PIN_VNOM = 7;

   // timing
   localparam int PZ_CLK_PERIOD_NS = 10;
   localparam int PZ_SAMPLE_NS     = 10000;
   localparam int PZ_SAMPLE_CYCLES = PZ_SAMPLE_NS / PZ_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      PZ_S_INIT = 2'b01,
      PZ_S_RUN  = 2'b10
   } pzps_fsm_t;

   typedef struct packed {
      logic [2:0] low_pri;   // primary low zone strap code 0..4
      logic [2:0] low_sec;   // secondary low zone strap code 0..4
      logic [7:0] th1;       // shed thresholds, ff when saturated
      logic [7:0] th2;
      logic [7:0] th3;
      logic [2:0] ll_idx;    // load-line/address strap code 0..7
   } pzps_strap_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pzps_reg_req_t;

   typedef struct packed {
      pzps_fsm_t  st;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] pin;
      logic [3:0] act;
      logic [2:0] nph;
      logic [2:0] lpri;
      logic [2:0] lsec;
      logic [7:0] th1;
      logic [7:0] th2;
      logic [7:0] th3;
      logic [7:0] hyst;
      logic [7:0] dly;
      logic [7:0] lowz;
      logic [6:0] llp;
      logic [6:0] addr;
      logic       en_d;
      logic       nominal;
      logic       left_low;
      logic [1:0] psi;
      logic [2:0] zone;
      logic [15:0] tick_cnt;
      logic [7:0] step_cnt;
      logic [7:0] cur;
      logic [7:0] rdata;
      logic [3:0] pwm;
   } pzps_state_t;

endpackage

// file: pzps_selector.sv
`timescale 1ns/100ps
module pzps_selector #(
   parameter int SAMPLE_CYCLES = pzps_pkg::PZ_SAMPLE_CYCLES
)(
   input  wire logic                  clock,               // 100 MHz
   input  wire logic                  rst,                 // sync, high
   input  wire logic [3:0]            phase_sense_pin,     // high: above
   input  wire logic [1:0]            power_saving_select, // low/mid/high
   input  wire logic                  enable,              // pin
   input  wire logic                  vout_nominal,        // pin level
   input  wire pzps_pkg::pzps_strap_t straps,              // measured codes
   input  wire logic                  strap_done,          // codes valid
   input  wire logic [7:0]            total_current_monitor, // adc code
   input  wire pzps_pkg::pzps_reg_req_t reg_req,           // from 2-wire
   output logic [7:0]                 reg_rdata,           // read data
   output logic [3:0]                 phase_pulse_output,  // phase enables
   output logic [2:0]                 power_zone,          // current zone
   output logic [6:0]                 slave_address,       // strap address
   output logic [6:0]                 load_line_percentage, // percent
   output logic                       init_done            // straps held
);
   import pzps_pkg::*;

   if (SAMPLE_CYCLES < 2 || SAMPLE_CYCLES > 65535) begin : g_bad
      $error("SAMPLE_CYCLES out of range");
   end

   localparam logic [15:0] SAMPLE_LAST = 16'(SAMPLE_CYCLES - 1);

   pzps_state_t r_reg;
   pzps_state_t r_next;

   logic [2:0] tgt;
   logic [2:0] t_dn;
   logic [2:0] t_up;
   logic [2:0] nxt;
   logic       tick;
   logic       en;
   logic       is_mid;
   logic [2:0] low_code;

   // zone reachable for a phase count
   function automatic logic [2:0] fit_zone(input logic [2:0] z,
                                           input logic [2:0] n);
      if (n == 3'h4)
         return z;
      else if (n == 3'h1)
         return (z == PZ_ZONE4) ? PZ_ZONE4 : PZ_ZONE0;
      else
         return (z == PZ_ZONE2) ? PZ_ZONE0 : z;
   endfunction

   function automatic logic th_on(input logic [7:0] th);
      return th != PZ_TH_OFF;
   endfunction

   function automatic logic [7:0] sub_sat(input logic [7:0] a,
                                          input logic [7:0] b);
      return (a > b) ? 8'(a - b) : 8'h00;
   endfunction

   // disabled thresholds never match, so their zone is skipped
   function automatic logic [2:0] zone_of(input logic [7:0] c,
                                          input logic [7:0] h,
                                          input pzps_state_t s);
      if (th_on(s.th3) && c > sub_sat(s.th3, h))
         return PZ_ZONE0;
      else if (th_on(s.th2) && c > sub_sat(s.th2, h))
         return PZ_ZONE2;
      else if (th_on(s.th1) && c > sub_sat(s.th1, h))
         return PZ_ZONE3;
      else
         return PZ_ZONE4;
   endfunction

   function automatic logic [2:0] fixed_zone(input logic [2:0] code,
                                             input logic [2:0] n);
      logic [2:0] z;
      z = (code <= 3'h1) ? PZ_ZONE0 :
          (code == 3'h2) ? PZ_ZONE2 :
          (code == 3'h3) ? PZ_ZONE3 : PZ_ZONE4;
      return fit_zone(z, n);
   endfunction

   // next enabled zone above z; low mode forces its target enabled
   function automatic logic [2:0] next_up(input logic [2:0] z,
                                          input logic mid,
                                          input pzps_state_t s);
      if (z < PZ_ZONE2 && fit_zone(PZ_ZONE2, s.nph) == PZ_ZONE2 &&
          !(mid && !th_on(s.th2)))
         return PZ_ZONE2;
      else if (z < PZ_ZONE3 && fit_zone(PZ_ZONE3, s.nph) == PZ_ZONE3 &&
               !(mid && !th_on(s.th1)))
         return PZ_ZONE3;
      else
         return PZ_ZONE4;
   endfunction

   always_comb begin
      r_next = r_reg;
      tgt = PZ_ZONE0;
      t_dn = PZ_ZONE0;
      t_up = PZ_ZONE0;
      nxt = PZ_ZONE0;
      low_code = 3'h0;
      en = r_reg.pin[PZ_PIN_EN];
      is_mid = (r_reg.psi == PZ_PSI_MID);
      tick = (r_reg.tick_cnt == SAMPLE_LAST);

      // pins: three stages, accepted once stages two and three agree
      r_next.s1 = {vout_nominal, enable, power_saving_select,
                   phase_sense_pin};
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.pin = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) |
                   (r_reg.pin & (r_reg.s2 ^ r_reg.s3));
      r_next.rdata = 8'h00;

      case (r_reg.st)
         PZ_S_INIT: begin
            if (strap_done) begin
               // phase1 is always kept; later phases only while contiguous
               r_next.act[0] = 1'b1;                               // [R1]
               r_next.act[1] = ~r_reg.pin[1];                      // [R2]
               r_next.act[2] = ~r_reg.pin[1] & ~r_reg.pin[2];      // [R2]
               r_next.act[3] = ~r_reg.pin[1] & ~r_reg.pin[2] &
                               ~r_reg.pin[3];                      // [R2]
               r_next.nph = r_reg.pin[1] ? 3'h1 :
                            r_reg.pin[2] ? 3'h2 :
                            r_reg.pin[3] ? 3'h3 : 3'h4;            // [R1]
               r_next.lpri = straps.low_pri;                       // [R4]
               r_next.lsec = straps.low_sec;                       // [R4]
               r_next.th1 = straps.th1;                            // [R9]
               r_next.th2 = straps.th2;
               r_next.th3 = straps.th3;
               r_next.lowz = {2'h0, straps.low_sec, straps.low_pri};
               r_next.llp = straps.ll_idx[0] ? PZ_LL_NONE
                                             : PZ_LL_FULL;         // [R16]
               r_next.addr = 7'(PZ_ADDR_BASE +
                             {1'b0, straps.ll_idx[2:1], 4'h0});    // [R16]
               r_next.st = PZ_S_RUN;                               // [R20]
            end
         end
         PZ_S_RUN: begin
            r_next.tick_cnt = tick ? 16'h0000 : 16'(r_reg.tick_cnt + 1);
            if (tick)
               r_next.cur = total_current_monitor;                 // [R8]

            // select level tracking
            r_next.en_d = en;
            if (en && !r_reg.en_d) begin
               r_next.psi = r_reg.pin[PZ_PIN_PSI +: 2];            // [R4]
               r_next.nominal = 1'b0;
               r_next.left_low = 1'b0;
            end else if (en) begin
               if (r_reg.pin[PZ_PIN_VNOM])
                  r_next.nominal = 1'b1;
               if (r_reg.nominal)
                  r_next.psi = r_reg.pin[PZ_PIN_PSI +: 2];         // [R6]
               if (r_reg.psi != PZ_PSI_LOW)
                  r_next.left_low = 1'b1;                          // [R13]
            end

            // target zone
            t_dn = fit_zone(zone_of(r_reg.cur, 8'h00, r_reg),
                            r_reg.nph);                            // [R14]
            t_up = fit_zone(zone_of(r_reg.cur, r_reg.hyst, r_reg),
                            r_reg.nph);                            // [R19]
            if (r_reg.left_low)
               low_code = r_reg.lowz[PZ_LOW_SEC_EN] ?
                          r_reg.lowz[PZ_LOW_PRI_LSB +: 3] :
                          r_reg.lpri;                              // [R13]
            else
               low_code = r_reg.lowz[PZ_LOW_SEC_EN] ?
                          r_reg.lowz[PZ_LOW_SEC_LSB +: 3] :
                          r_reg.lsec;                              // [R11]
            case (r_reg.psi)
               PZ_PSI_HIGH: tgt = PZ_ZONE0;                        // [R7]
               PZ_PSI_MID: begin
                  if (!r_reg.nominal)
                     tgt = PZ_ZONE0;                               // [R10]
                  else if (t_dn < r_reg.zone)
                     tgt = t_dn;
                  else if (t_up > r_reg.zone)
                     tgt = t_up;
                  else
                     tgt = r_reg.zone;
               end
               PZ_PSI_LOW: tgt = fixed_zone(low_code, r_reg.nph);  // [R15]
               default: tgt = PZ_ZONE0;
            endcase

            // zone mover: delay counted in 10 us sample periods
            nxt = next_up(r_reg.zone, is_mid, r_reg);
            if (!en) begin
               r_next.zone = PZ_ZONE0;
               r_next.step_cnt = 8'h00;
            end else if (tgt < r_reg.zone) begin
               r_next.zone = tgt;                                  // [R18]
               r_next.step_cnt = 8'h00;
            end else if (tgt > r_reg.zone) begin
               if (tick) begin
                  if (9'(r_reg.step_cnt) + 9'h001 >= 9'(r_reg.dly)) begin
                     r_next.zone = (nxt > tgt) ? tgt : nxt;        // [R18]
                     r_next.step_cnt = 8'h00;
                  end else begin
                     r_next.step_cnt = 8'(r_reg.step_cnt + 1);
                  end
               end
            end else begin
               r_next.step_cnt = 8'h00;
            end

            // register writes
            if (reg_req.wr) begin
               case (reg_req.addr)
                  PZ_REG_TH1:      r_next.th1 = reg_req.wdata;     // [R5]
                  PZ_REG_TH2:      r_next.th2 = reg_req.wdata;     // [R5]
                  PZ_REG_TH3:      r_next.th3 = reg_req.wdata;     // [R5]
                  PZ_REG_HYST:     r_next.hyst = reg_req.wdata;    // [R19]
                  PZ_REG_DELAY:    r_next.dly = reg_req.wdata;     // [R18]
                  PZ_REG_LOWZONE:  r_next.lowz = reg_req.wdata;    // [R12]
                  PZ_REG_LOADLINE: r_next.llp = reg_req.wdata[6:0]; // [R17]
                  default: ;
               endcase
            end
         end
         default: r_next.st = PZ_S_INIT;
      endcase

      // reads answer one cycle later; unmapped reads give zero
      if (reg_req.rd) begin
         case (reg_req.addr)
            PZ_REG_PHASE_STAT: r_next.rdata = {4'h0, r_reg.act};   // [R3]
            PZ_REG_TH1:        r_next.rdata = r_reg.th1;
            PZ_REG_TH2:        r_next.rdata = r_reg.th2;
            PZ_REG_TH3:        r_next.rdata = r_reg.th3;
            PZ_REG_HYST:       r_next.rdata = r_reg.hyst;
            PZ_REG_DELAY:      r_next.rdata = r_reg.dly;
            PZ_REG_LOWZONE:    r_next.rdata = r_reg.lowz;
            PZ_REG_LOADLINE:   r_next.rdata = {1'b0, r_reg.llp};
            PZ_REG_ZONE_STAT:  r_next.rdata = {5'h00, r_reg.zone};
            default:           r_next.rdata = 8'h00;
         endcase
      end

      // zone 2 runs phases 1 and 3, zones 3 and 4 phase 1 only
      if (!en || r_reg.st != PZ_S_RUN)
         r_next.pwm = 4'h0;
      else if (r_next.zone == PZ_ZONE0)
         r_next.pwm = r_reg.act;                                   // [R7]
      else if (r_next.zone == PZ_ZONE2)
         r_next.pwm = 4'h5;
      else
         r_next.pwm = 4'h1;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         r_reg <= '0;
         r_reg.st <= PZ_S_INIT;
         r_reg.act <= 4'hf;
         r_reg.nph <= 3'h4;
         r_reg.th1 <= PZ_TH_OFF;
         r_reg.th2 <= PZ_TH_OFF;
         r_reg.th3 <= PZ_TH_OFF;
         r_reg.hyst <= PZ_HYST_RST;
         r_reg.dly <= PZ_DELAY_RST;
         r_reg.llp <= PZ_LL_FULL;
         r_reg.addr <= PZ_ADDR_BASE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata = r_reg.rdata;
   assign phase_pulse_output = r_reg.pwm;
   assign power_zone = r_reg.zone;
   assign slave_address = r_reg.addr;
   assign load_line_percentage = r_reg.llp;
   assign init_done = (r_reg.st == PZ_S_RUN);

   // helper: cycles since the zone last changed
   logic [31:0] since_chg;
   always_ff @(posedge clock) begin
      if (rst)
         since_chg <= 32'h0;
      else if (r_next.zone != r_reg.zone)
         since_chg <= 32'h0;
      else if (since_chg != 32'hffffffff)
         since_chg <= since_chg + 32'h1;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_capture;
      r_reg.st == PZ_S_INIT && strap_done;
   endsequence

   sequence s_frozen;
      en && r_reg.en_d && !r_reg.nominal;
   endsequence

   a_phase_contig: assert property (                              // [R2]
      r_reg.act inside {4'h1, 4'h3, 4'h7, 4'hf})
      else $error("phase set not contiguous");

   a_phase_read: assert property (                                // [R3]
      reg_req.rd && reg_req.addr == PZ_REG_PHASE_STAT
      |=> reg_rdata == {4'h0, $past(r_reg.act)})
      else $error("phase status read wrong");

   a_select_frozen: assert property (s_frozen |=> $stable(r_reg.psi)) // [R6]
      else $error("select changed before nominal");

   a_high_zero: assert property (                                 // [R7]
      init_done && en && r_reg.psi == PZ_PSI_HIGH
      |=> power_zone == PZ_ZONE0 && phase_pulse_output == $past(r_reg.act))
      else $error("select high left zone zero");

   a_th1_off: assert property (                                   // [R9]
      init_done && is_mid && r_reg.th1 == PZ_TH_OFF &&
      power_zone != PZ_ZONE3
      |=> power_zone != PZ_ZONE3)
      else $error("zone of disabled threshold entered");

   a_shed_inhibit: assert property (                              // [R10]
      init_done && r_reg.en_d && en && !r_reg.nominal &&
      r_reg.psi == PZ_PSI_MID |=> power_zone == PZ_ZONE0)
      else $error("shedding before nominal");

   a_down_now: assert property (                                  // [R18]
      init_done && en && is_mid && r_reg.nominal && t_dn < power_zone
      |=> power_zone == $past(t_dn))
      else $error("downward zone move delayed");

   a_up_paced: assert property (                                  // [R18]
      init_done && r_next.zone > r_reg.zone && r_reg.dly > 8'h01
      |-> since_chg >= 32'(r_reg.dly - 8'h01) * 32'(SAMPLE_CYCLES))
      else $error("upward zone step too early");

   a_strap_capture: assert property (s_capture |=>                // [R16]
      slave_address == 7'(PZ_ADDR_BASE +
         {1'b0, $past(straps.ll_idx[2:1]), 4'h0}))
      else $error("address not taken from strap");

   a_strap_hold: assert property (                                // [R20]
      init_done |=> init_done && $stable(slave_address))
      else $error("strap result changed after capture");

endmodule

// file: pzps_psi_host.sv
`timescale 1ns/100ps
module pzps_psi_host (
   input  wire logic       clock,              // system clock
   input  wire logic [1:0] want,               // level asked for
   input  wire logic [7:0] lag,                // cycles before pin follows
   output logic      [1:0] power_saving_select // pin level
);
   logic [7:0] wait_cnt;
   initial begin
      power_saving_select = 2'h2;
      wait_cnt = 8'h00;
   end
   // a slow host lets the pin trail its own decision, as real ones may
   always @(negedge clock) begin
      if (want == power_saving_select) begin
         wait_cnt <= 8'h00;
      end else if (wait_cnt >= lag) begin
         power_saving_select <= want;
         wait_cnt <= 8'h00;
      end else begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end
endmodule

// file: pzps_selector_tb_top.sv
`timescale 1ns/100ps
module pzps_selector_tb_top;
   import pzps_pkg::*;
   logic          clock, rst, enable, vnom, strap_done, rd_prev, init_done;
   logic [3:0]    sense, pwm;
   logic [1:0]    want, psi;
   logic [7:0]    lag, cur, reg_rdata, d;
   logic [2:0]    zone, idx;
   logic [6:0]    addr, llp;
   pzps_strap_t   straps;
   pzps_reg_req_t req;
   int            fail_count, compares, cycles, zage;
   logic [7:0]    rq[$];
   logic [6:0]    zq[$];
   logic [3:0]    sense_tab[4] = '{4'h8, 4'h4, 4'h6, 4'h0};
   logic [3:0]    act_tab[4]   = '{4'h7, 4'h3, 4'h1, 4'hf};

   pzps_selector #(.SAMPLE_CYCLES(20)) u_dut (
      .clock(clock), .rst(rst), .phase_sense_pin(sense),
      .power_saving_select(psi), .enable(enable), .vout_nominal(vnom),
      .straps(straps), .strap_done(strap_done),
      .total_current_monitor(cur), .reg_req(req), .reg_rdata(reg_rdata),
      .phase_pulse_output(pwm), .power_zone(zone), .slave_address(addr),
      .load_line_percentage(llp), .init_done(init_done));
   pzps_psi_host u_host (
      .clock(clock), .want(want), .lag(lag), .power_saving_select(psi));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic report(string msg);
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask
   task automatic cmp_val(logic [7:0] got, logic [7:0] exp, string what);
      compares++;
      if (got !== exp) report(what);
   endtask
   task automatic cmp_zone(logic [6:0] got, logic [6:0] exp);
      compares++;
      if (got !== exp) report("zone or phase enables");
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic reg_wr(logic [7:0] a, logic [7:0] v);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      tick(1);
      req = '0;
      tick(1);
   endtask
   task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
      rq.push_back(exp);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      tick(1);
      req = '0;
      tick(1);
   endtask
   task automatic expect_zone(logic [2:0] z, logic [3:0] p);
      zq.push_back({z, p});
      while (zq.size() > 0) tick(1);
   endtask
   task automatic power_up(logic [3:0] s, logic [2:0] ll);
      rst = 1'b1;
      enable = 1'b0;
      vnom = 1'b0;
      strap_done = 1'b0;
      sense = s;
      straps = '{low_pri: 3'h2, low_sec: 3'h3, th1: 8'($urandom),
                 th2: 8'($urandom), th3: 8'($urandom), ll_idx: ll};
      tick(20);
      rst = 1'b0;
      tick(6);
      cmp_val({7'h0, init_done}, 8'h00, "init before straps");
      strap_done = 1'b1;
      tick(2);
      cmp_val({7'h0, init_done}, 8'h01, "init after straps");
   endtask

   // read data lands one cycle after the request is taken
   always @(posedge clock) begin
      if (rd_prev === 1'b1 && rq.size() > 0) begin
         cmp_val(reg_rdata, rq.pop_front(), "read data");
      end
      rd_prev <= req.rd;
   end
   // zones step slowly, so each note waits a bounded time for its match
   always @(negedge clock) begin
      if (zq.size() > 0) begin
         zage++;
         if ({zone, pwm} === zq[0] || zage > 3000) begin
            cmp_zone({zone, pwm}, zq.pop_front());
            zage = 0;
         end
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         report("timeout");
         wrap_up();
      end
   end

   initial begin
      {rst, enable, vnom, strap_done, rd_prev, req} = '0;
      {sense, cur, lag, straps, fail_count, compares, cycles, zage} = '0;
      want = PZ_PSI_HIGH;
      void'($urandom(99));
      for (int i = 0; i < 4; i++) begin
         idx = 3'($urandom % 8);
         power_up(sense_tab[i], idx);
         reg_rd(PZ_REG_PHASE_STAT, {4'h0, act_tab[i]});
         d = {1'b0, PZ_ADDR_BASE + {idx[2:1], 4'h0}};
         cmp_val({1'b0, addr}, d, "addr");
         d = {1'b0, idx[0] ? PZ_LL_NONE : PZ_LL_FULL};
         cmp_val({1'b0, llp}, d, "ll");
         reg_rd(PZ_REG_TH1, straps.th1);
         reg_rd(PZ_REG_TH3, straps.th3);
      end
      reg_rd(PZ_REG_HYST, PZ_HYST_RST);
      reg_rd(PZ_REG_DELAY, PZ_DELAY_RST);
      reg_rd(8'h3f, 8'h00);
      reg_wr(PZ_REG_PHASE_STAT, 8'h00);
      reg_rd(PZ_REG_PHASE_STAT, 8'h0f);
      d = 8'($urandom % 128);
      reg_wr(PZ_REG_LOADLINE, d);
      cmp_val({1'b0, llp}, {1'b0, d[6:0]}, "load line write");
      reg_wr(PZ_REG_TH1, 8'h40);
      reg_wr(PZ_REG_TH2, 8'h80);
      reg_wr(PZ_REG_TH3, 8'hc0);
      reg_rd(PZ_REG_TH2, 8'h80);
      reg_wr(PZ_REG_DELAY, 8'h01);
      want = PZ_PSI_LOW;
      tick(10);
      enable = 1'b1;
      expect_zone(PZ_ZONE3, 4'h1);
      want = PZ_PSI_HIGH;
      tick(200);
      expect_zone(PZ_ZONE3, 4'h1);
      vnom = 1'b1;
      expect_zone(PZ_ZONE0, 4'hf);
      lag = 8'd30;
      want = PZ_PSI_LOW;
      expect_zone(PZ_ZONE2, 4'h5);
      reg_wr(PZ_REG_LOWZONE, 8'ha3);
      expect_zone(PZ_ZONE3, 4'h1);
      lag = 8'd0;
      cur = 8'h10;
      want = PZ_PSI_MID;
      expect_zone(PZ_ZONE4, 4'h1);
      cur = 8'hd0;
      expect_zone(PZ_ZONE0, 4'hf);
      cur = 8'h90;
      expect_zone(PZ_ZONE2, 4'h5);
      cur = 8'h78;
      tick(200);
      expect_zone(PZ_ZONE2, 4'h5);
      cur = 8'h50;
      expect_zone(PZ_ZONE3, 4'h1);
      enable = 1'b0;
      vnom = 1'b0;
      cur = 8'h10;
      expect_zone(PZ_ZONE0, 4'h0);
      enable = 1'b1;
      tick(300);
      expect_zone(PZ_ZONE0, 4'hf);
      reg_wr(PZ_REG_TH1, PZ_TH_OFF);
      reg_wr(PZ_REG_DELAY, 8'h03);
      vnom = 1'b1;
      expect_zone(PZ_ZONE4, 4'h1);
      enable = 1'b0;
      vnom = 1'b0;
      want = PZ_PSI_LOW;
      tick(10);
      enable = 1'b1;
      expect_zone(PZ_ZONE4, 4'h1);
      reg_wr(PZ_REG_LOWZONE, 8'h93);
      expect_zone(PZ_ZONE2, 4'h5);
      reg_rd(PZ_REG_LOWZONE, 8'h93);
      reg_rd(PZ_REG_ZONE_STAT, {5'h00, PZ_ZONE2});
      wrap_up();
   end
endmodule
